// File: core/pplc_consts.vh
// Constants for the per-port link control block: register map, field positions, resets and timing.
// Assumes a 20 MHz core clock and a 32-bit APB register bus.
`ifndef PPLC_CONSTS_VH
`define PPLC_CONSTS_VH

// Register byte offsets
`define PPLC_OFF_LINK_CTRL     12'h000
`define PPLC_OFF_LINK_CTRL2    12'h004
`define PPLC_OFF_REJ_TIMER     12'h008
`define PPLC_OFF_PHY_CFG0      12'h00C
`define PPLC_OFF_PRBS_SEED     12'h010
`define PPLC_OFF_PORT_STATUS   12'h014

// link_control_reg fields
`define PPLC_LC_ASPM_L1_BIT    1
`define PPLC_LC_LINK_DIS_BIT   4
// link_control_2_reg field
`define PPLC_LC2_DEEMPH_BIT    6
// l1_reject_timer_ctrl fields
`define PPLC_RT_GAP_MSB        9
`define PPLC_RT_START_SEL_BIT  16
// phy_link_config0 fields
`define PPLC_PC_XLINK_DIS_BIT  0
`define PPLC_PC_SPEED_INIT_BIT 1
// switch_port_status_reg fields
`define PPLC_ST_ROLE_BIT       0
`define PPLC_ST_DLUP_BIT       1
`define PPLC_ST_L1_BIT         2
`define PPLC_ST_GAP_BIT        3
`define PPLC_ST_ACT_BIT        4
`define PPLC_ST_DEEMPH_BIT     5

// Gap field unit is 100 ns; 95 units gives 9.5 us, 640 units 64 us
`define PPLC_GAP_UNIT_NS       100
`define PPLC_GAP_RESET         10'h05F
`define PPLC_CLK_NS            50
`define PPLC_GAP_UNIT_CYC      (`PPLC_GAP_UNIT_NS / `PPLC_CLK_NS)

// Activity hold 200 ms, expander update period 40 ms
`define PPLC_ACT_HOLD_MS       200
`define PPLC_EXP_PERIOD_MS     40
`define PPLC_EXP_PERIOD_CYC    (`PPLC_EXP_PERIOD_MS * 20000)
`define PPLC_ACT_PERIODS       (`PPLC_ACT_HOLD_MS / `PPLC_EXP_PERIOD_MS)

// LTSSM-like link states reported in
`define PPLC_LS_DETECT         3'h0
`define PPLC_LS_L0             3'h1
`define PPLC_LS_L0S            3'h2
`define PPLC_LS_L1             3'h3
`define PPLC_LS_RECOVERY       3'h4
`define PPLC_LS_HOTRESET       3'h5
`define PPLC_LS_DISABLED       3'h6

`endif

// File: core/pplc_gap_timer.v
// Rejection gap timer: counts a programmed number of 100 ns units after arming.
// Assumes a 20 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
`include "pplc_consts.vh"

module pplc_gap_timer #(
  parameter GAP_W = 10
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire             arm,
  input  wire             countEnable,
  input  wire [GAP_W-1:0] gapUnits,
  output wire             gapRunning
);

  reg  [GAP_W-1:0] unitCnt_q;
  reg  [3:0]       subCnt_q;
  reg              running_q;
  reg              started_q;

  // Last sub-unit count as a vector, so the compare below has matching widths
  localparam integer SUB_LAST = `PPLC_GAP_UNIT_CYC - 1;
  wire [31:0]      subLastW = SUB_LAST;

  // Arm starts a wait; counting holds off until countEnable is first high, then runs on with countEnable ignored
  always @(posedge ref_clk) begin
    if (reset) begin
      unitCnt_q <= {GAP_W{1'b0}};
      subCnt_q  <= 4'h0;
      running_q <= 1'b0;
      started_q <= 1'b0;
    end else if (arm) begin
      unitCnt_q <= gapUnits;
      subCnt_q  <= 4'h0;
      running_q <= 1'b1;
      started_q <= 1'b0;
    end else if (running_q && (countEnable || started_q)) begin
      started_q <= 1'b1;
      if (unitCnt_q == {GAP_W{1'b0}}) begin
        running_q <= 1'b0;
      end else if (subCnt_q == subLastW[3:0]) begin
        subCnt_q  <= 4'h0;
        unitCnt_q <= unitCnt_q - 1'b1;
      end else begin
        subCnt_q <= subCnt_q + 4'h1;
      end
    end
  end

  assign gapRunning = running_q;

endmodule // pplc_gap_timer

// File: core/pplc_port_link_ctrl.v
// Per-port link control of a switch port: L1 accept/reject, gap timer, status outputs,
// de-emphasis choice, crosslink role and hot reset / disable directives.
// Assumes an APB master on the same 20 MHz clock and a physical layer that reports events as pulses.
`timescale 1ns/1ps
`include "pplc_consts.vh"

// How it works
// - Accepted L1 request: send PM_Request_Ack continuously until partner electrical idle.
// - Rejected L1 request: send exactly one PM_Active_State_Nak pulse.
// - Requests within the gap after a rejection are ignored, no answer sent.
// - Each port has its own gap timer, programmable in 100 ns steps.
// - Gap timer resets to 9.5 us.
// - By default the gap count starts right at the rejection.
// - With start select set, counting waits for idle receive lanes.
// - Link-up output low while data link is up: L0, L0s, L1, Recovery.
// - Activity output low on any non-vendor TLP sent or received.
// - Activity stays asserted at least 200 ms, five 40 ms expander periods.
// - Gen1 uses -3.5dB; Gen2 uses the selected de-emphasis.
// - De-emphasis settled in Recovery, upstream component decides, same on all lanes.
// - Upstream port advertises its own selection and adopts partner decision.
// - Downstream port ignores partner preference and applies its own selection.
// - Status shows whether the PHY trained as upstream or downstream lanes.
// - Upstream-upstream crosslink stays Gen1 unless speed change initiate bit set.
// - Crosslink enabled after reset, suppressed while crosslink disable bit set.
// - Downstream-mode port enters hot reset on hot reset training sets, registers kept.
// - Directed hot reset only when trained as downstream lanes, through Recovery.
// - Link disable bit sends downstream-mode port through Recovery to Disabled.
module pplc_port_link_ctrl #(
  parameter GAP_W          = 10,
  parameter EXP_PERIOD_CYC = `PPLC_EXP_PERIOD_CYC
) (
  input  wire        ref_clk,
  input  wire        reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Port configuration and physical layer status
  input  wire        isUpstreamPort,
  input  wire        trainedDownLanes,
  input  wire        isCrosslink,
  input  wire        gen2Rate,
  input  wire [2:0]  linkState,
  // L1 handshake
  input  wire        l1ReqRx,
  input  wire        l1AcceptOk,
  input  wire        elecIdleRx,
  input  wire        rxLanesActive,
  output reg         pmRequestAckTx,
  output reg         pmNakTx,
  // Traffic
  input  wire        tlpTx,
  input  wire        tlpRx,
  input  wire        tlpIsVendorMsg,
  // De-emphasis
  input  wire        partnerDeemph,
  output reg         deemphAdvertise,
  output reg         deemphApplied,
  // Crosslink, speed, hot reset and disable
  input  wire        hotResetTsRx,
  input  wire        disabledTsRx,
  input  wire        hotResetDirect,
  output reg         crosslinkEnable,
  output reg         speedChangeReq,
  output reg         enterRecovery,
  output reg         enterHotReset,
  output reg         enterDisabled,
  // Expander status
  output reg         link_up_led_n,
  output reg         activity_led_n
);

  // L1 handshake states
  localparam L1_IDLE = 2'd0;
  localparam L1_ACK  = 2'd1;
  localparam L1_WAIT = 2'd2;

  // Activity hold length in expander periods, cut to the period counter width
  localparam integer ACT_PERIODS = `PPLC_ACT_PERIODS;
  wire [31:0]        actPeriodsW = ACT_PERIODS;

  reg  [31:0]      linkCtrl_q;
  reg  [31:0]      linkCtrl2_q;
  reg  [GAP_W-1:0] gapUnits_q;
  reg              startSel_q;
  reg              xlinkDis_q;
  reg              speedInit_q;
  reg  [31:0]      prbsSeed_q;
  reg  [1:0]       l1State_q;
  reg              l1ReqSeen_q;
  reg              rejArm_q;
  reg  [31:0]      expCnt_q;
  reg              expTick_q;
  reg  [2:0]       actPeriods_q;
  reg              actPending_q;
  reg              recovHr_q;
  reg              recovDis_q;
  reg  [31:0]      rdData_d;
  reg              rdErr_d;
  wire             gapRunning;
  wire             apbAccess;
  wire             dlUp;
  wire             l1Enabled;
  wire             downMode;
  wire             newL1Req;
  wire             tlpSeen;

  assign apbAccess = psel && penable && !pready;
  assign l1Enabled = linkCtrl_q[`PPLC_LC_ASPM_L1_BIT];
  assign downMode  = !isUpstreamPort;
  assign dlUp      = (linkState == `PPLC_LS_L0) || (linkState == `PPLC_LS_L0S) ||
                     (linkState == `PPLC_LS_L1) || (linkState == `PPLC_LS_RECOVERY);
  // A request only counts on its rising edge and outside the gap window
  assign newL1Req  = l1ReqRx && !l1ReqSeen_q && !gapRunning;
  assign tlpSeen   = (tlpTx || tlpRx) && !tlpIsVendorMsg;

  // APB registers; one wait state so pready always comes from a flop
  always @(posedge ref_clk) begin
    if (reset) begin
      linkCtrl_q  <= 32'h00000000;
      linkCtrl2_q <= 32'h00000000;
      gapUnits_q  <= `PPLC_GAP_RESET;
      startSel_q  <= 1'b0;
      xlinkDis_q  <= 1'b0;
      speedInit_q <= 1'b0;
      prbsSeed_q  <= 32'h00000000;
      prdata      <= 32'h00000000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess && rdErr_d;
      if (apbAccess && !pwrite) begin
        prdata <= rdData_d;
      end
      if (apbAccess && pwrite) begin
        case (paddr)
          `PPLC_OFF_LINK_CTRL:  linkCtrl_q  <= pwdata;
          `PPLC_OFF_LINK_CTRL2: linkCtrl2_q <= pwdata;
          `PPLC_OFF_REJ_TIMER: begin
            gapUnits_q <= pwdata[`PPLC_RT_GAP_MSB:0];
            startSel_q <= pwdata[`PPLC_RT_START_SEL_BIT];
          end
          `PPLC_OFF_PHY_CFG0: begin
            xlinkDis_q  <= pwdata[`PPLC_PC_XLINK_DIS_BIT];
            speedInit_q <= pwdata[`PPLC_PC_SPEED_INIT_BIT];
          end
          `PPLC_OFF_PRBS_SEED:  prbsSeed_q  <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // Read mux; unmapped addresses answer with pslverr and zero data
  always @* begin
    rdData_d = 32'h00000000;
    rdErr_d  = 1'b0;
    case (paddr)
      `PPLC_OFF_LINK_CTRL:  rdData_d = linkCtrl_q;
      `PPLC_OFF_LINK_CTRL2: rdData_d = linkCtrl2_q;
      `PPLC_OFF_REJ_TIMER: begin
        rdData_d[`PPLC_RT_GAP_MSB:0]     = gapUnits_q;
        rdData_d[`PPLC_RT_START_SEL_BIT] = startSel_q;
      end
      `PPLC_OFF_PHY_CFG0: begin
        rdData_d[`PPLC_PC_XLINK_DIS_BIT]  = xlinkDis_q;
        rdData_d[`PPLC_PC_SPEED_INIT_BIT] = speedInit_q;
      end
      `PPLC_OFF_PRBS_SEED:  rdData_d = prbsSeed_q;
      `PPLC_OFF_PORT_STATUS: begin
        rdData_d[`PPLC_ST_ROLE_BIT]   = trainedDownLanes;
        rdData_d[`PPLC_ST_DLUP_BIT]   = dlUp;
        rdData_d[`PPLC_ST_L1_BIT]     = (l1State_q == L1_ACK);
        rdData_d[`PPLC_ST_GAP_BIT]    = gapRunning;
        rdData_d[`PPLC_ST_ACT_BIT]    = !activity_led_n;
        rdData_d[`PPLC_ST_DEEMPH_BIT] = deemphApplied;
      end
      default: rdErr_d = 1'b1;
    endcase
  end

  // L1 entry handshake, downstream-mode ports only
  always @(posedge ref_clk) begin
    if (reset) begin
      l1State_q      <= L1_IDLE;
      l1ReqSeen_q    <= 1'b0;
      rejArm_q       <= 1'b0;
      pmRequestAckTx <= 1'b0;
      pmNakTx        <= 1'b0;
    end else begin
      l1ReqSeen_q <= l1ReqRx;
      rejArm_q    <= 1'b0;
      pmNakTx     <= 1'b0;
      case (l1State_q)
        L1_IDLE: begin
          if (newL1Req && downMode) begin
            if (l1Enabled && l1AcceptOk) begin
              l1State_q      <= L1_ACK;
              pmRequestAckTx <= 1'b1;
            end else begin
              pmNakTx   <= 1'b1;
              rejArm_q  <= 1'b1;
              l1State_q <= L1_WAIT;
            end
          end
        end
        L1_ACK: begin
          // Keep acking until the partner goes electrically idle
          if (elecIdleRx) begin
            pmRequestAckTx <= 1'b0;
            l1State_q      <= L1_IDLE;
          end
        end
        L1_WAIT: begin
          // Partner must drop its request stream before a new one counts
          if (!l1ReqRx) begin
            l1State_q <= L1_IDLE;
          end
        end
        default: l1State_q <= L1_IDLE;
      endcase
    end
  end

  // Gap timer: default starts at once, alternative waits for quiet lanes
  pplc_gap_timer #(
    .GAP_W(GAP_W)
  ) u_gap_timer (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .arm         (rejArm_q),
    .countEnable (!startSel_q || !rxLanesActive),
    .gapUnits    (gapUnits_q),
    .gapRunning  (gapRunning)
  );

  // Expander update tick every 40 ms
  always @(posedge ref_clk) begin
    if (reset) begin
      expCnt_q  <= 32'h00000000;
      expTick_q <= 1'b0;
    end else if (expCnt_q == EXP_PERIOD_CYC - 1) begin
      expCnt_q  <= 32'h00000000;
      expTick_q <= 1'b1;
    end else begin
      expCnt_q  <= expCnt_q + 32'h00000001;
      expTick_q <= 1'b0;
    end
  end

  // Status outputs change only on expander ticks; activity holds five periods
  always @(posedge ref_clk) begin
    if (reset) begin
      link_up_led_n  <= 1'b1;
      activity_led_n <= 1'b1;
      actPeriods_q   <= 3'h0;
      actPending_q   <= 1'b0;
    end else begin
      if (tlpSeen) begin
        actPending_q <= 1'b1; // Set wins over the tick clear
      end else if (expTick_q) begin
        actPending_q <= 1'b0;
      end
      if (expTick_q) begin
        link_up_led_n <= !dlUp;
        if (actPending_q || tlpSeen) begin
          activity_led_n <= 1'b0;
          actPeriods_q   <= actPeriodsW[2:0];
        end else if (actPeriods_q > 3'h1) begin
          actPeriods_q <= actPeriods_q - 3'h1;
        end else begin
          actPeriods_q   <= 3'h0;
          activity_led_n <= 1'b1;
        end
      end
    end
  end

  // De-emphasis: Gen1 fixed -3.5dB (0); Gen2 by role
  always @(posedge ref_clk) begin
    if (reset) begin
      deemphAdvertise <= 1'b0;
      deemphApplied   <= 1'b0;
    end else begin
      deemphAdvertise <= linkCtrl2_q[`PPLC_LC2_DEEMPH_BIT];
      if (!gen2Rate) begin
        deemphApplied <= 1'b0;
      end else if (linkState == `PPLC_LS_RECOVERY) begin
        // Upstream port follows the partner's decision; downstream port decides alone
        deemphApplied <= isUpstreamPort ? partnerDeemph
                                        : linkCtrl2_q[`PPLC_LC2_DEEMPH_BIT];
      end
    end
  end

  // Crosslink, speed change, hot reset and disable directives
  always @(posedge ref_clk) begin
    if (reset) begin
      crosslinkEnable <= 1'b1;
      speedChangeReq  <= 1'b0;
      enterRecovery   <= 1'b0;
      enterHotReset   <= 1'b0;
      enterDisabled   <= 1'b0;
      recovHr_q       <= 1'b0;
      recovDis_q      <= 1'b0;
    end else begin
      crosslinkEnable <= !xlinkDis_q;
      // Upstream-to-upstream crosslink stays Gen1 unless software asks
      speedChangeReq  <= isUpstreamPort && isCrosslink && speedInit_q;
      enterRecovery   <= 1'b0;
      enterHotReset   <= 1'b0;
      enterDisabled   <= 1'b0;
      if (downMode && hotResetDirect && trainedDownLanes && !recovHr_q) begin
        recovHr_q     <= 1'b1;
        enterRecovery <= 1'b1;
      end
      if (downMode && linkCtrl_q[`PPLC_LC_LINK_DIS_BIT] && !recovDis_q) begin
        recovDis_q    <= 1'b1;
        enterRecovery <= 1'b1;
      end
      if (!linkCtrl_q[`PPLC_LC_LINK_DIS_BIT]) begin
        recovDis_q <= 1'b0;
      end
      if (linkState == `PPLC_LS_RECOVERY && recovHr_q) begin
        recovHr_q     <= 1'b0;
        enterHotReset <= 1'b1;
      end
      if (linkState == `PPLC_LS_RECOVERY && recovDis_q) begin
        enterDisabled <= 1'b1;
      end
      // Hot reset from training sets leaves registers untouched
      if (hotResetTsRx) begin
        enterHotReset <= 1'b1;
      end
      if (disabledTsRx) begin
        enterDisabled <= 1'b1;
      end
    end
  end

endmodule // pplc_port_link_ctrl

// File: testbench/pplc_link_monitor.sv
// Checker for the port link control block: L1 answers, de-emphasis, training set directives, activity hold.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
`include "pplc_consts.vh"
module pplc_link_monitor #(
  parameter EXP_PERIOD_CYC = 800000
) (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       isUpstreamPort,
  input wire logic       gen2Rate,
  input wire logic [2:0] linkState,
  input wire logic       l1ReqRx,
  input wire logic       l1AcceptOk,
  input wire logic       elecIdleRx,
  input wire logic       pmRequestAckTx,
  input wire logic       pmNakTx,
  input wire logic       tlpTx,
  input wire logic       tlpRx,
  input wire logic       tlpIsVendorMsg,
  input wire logic       partnerDeemph,
  input wire logic       deemphApplied,
  input wire logic       hotResetTsRx,
  input wire logic       disabledTsRx,
  input wire logic       enterHotReset,
  input wire logic       enterDisabled,
  input wire logic       activity_led_n
);
  localparam int HOLD = 5 * EXP_PERIOD_CYC;
  localparam int SEEN = EXP_PERIOD_CYC + 4;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [31:0] lowCnt_q;
  logic [31:0] since_q;
  logic        armed_q;
  // Low time of the activity output, judged when it is released
  always_ff @(posedge ref_clk) begin
    if (reset || activity_led_n) lowCnt_q <= 32'h0;
    else lowCnt_q <= lowCnt_q + 32'h1;
  end
  // Cycles since the last counted TLP; saturates so the check fires only once
  always_ff @(posedge ref_clk) begin
    if (reset) armed_q <= 1'h0;
    else if ((tlpTx || tlpRx) && !tlpIsVendorMsg) armed_q <= 1'h1;
    if (reset || ((tlpTx || tlpRx) && !tlpIsVendorMsg)) since_q <= 32'h0;
    else if (since_q < SEEN) since_q <= since_q + 32'h1;
  end
  sequence s_upRec2;
    isUpstreamPort && gen2Rate && linkState == `PPLC_LS_RECOVERY && $stable(partnerDeemph);
  endsequence
  sequence s_reqSeen;
    $past(l1ReqRx) && !$past(isUpstreamPort);
  endsequence
  property p_ackHold; pmRequestAckTx |=> pmRequestAckTx == !$past(elecIdleRx); endproperty
  property p_ackCause; $rose(pmRequestAckTx) |-> s_reqSeen ##0 $past(l1AcceptOk); endproperty
  property p_nakOnce; pmNakTx |=> !pmNakTx; endproperty
  property p_nakCause; $rose(pmNakTx) |-> s_reqSeen; endproperty
  property p_gen1; !gen2Rate [*2] |-> !deemphApplied; endproperty
  property p_upAdopt; s_upRec2 [*3] |-> deemphApplied == partnerDeemph; endproperty
  property p_hotTs; $rose(hotResetTsRx) && !isUpstreamPort |-> ##[1:4] enterHotReset; endproperty
  property p_disTs; $rose(disabledTsRx) |-> ##[1:4] enterDisabled; endproperty
  property p_actSeen; armed_q && since_q == SEEN - 1 |-> !activity_led_n; endproperty
  property p_actHold; $rose(activity_led_n) |-> lowCnt_q >= HOLD; endproperty
  a_ackHold: assert property (p_ackHold) else $error("ack not held until idle");
  a_ackCause: assert property (p_ackCause) else $error("ack without request");
  a_nakOnce: assert property (p_nakOnce) else $error("nak longer than one");
  a_nakCause: assert property (p_nakCause) else $error("nak without request");
  a_gen1: assert property (p_gen1) else $error("gen1 deemph not 3.5dB");
  a_upAdopt: assert property (p_upAdopt) else $error("upstream ignores partner");
  a_hotTs: assert property (p_hotTs) else $error("no hot reset on ts");
  a_disTs: assert property (p_disTs) else $error("no disable on ts");
  a_actSeen: assert property (p_actSeen) else $error("activity not shown");
  a_actHold: assert property (p_actHold) else $error("activity hold short");
endmodule // pplc_link_monitor

bind pplc_port_link_ctrl pplc_link_monitor #(.EXP_PERIOD_CYC(EXP_PERIOD_CYC)) u_mon (
  .ref_clk, .reset, .isUpstreamPort, .gen2Rate, .linkState, .l1ReqRx, .l1AcceptOk, .elecIdleRx,
  .pmRequestAckTx, .pmNakTx, .tlpTx, .tlpRx, .tlpIsVendorMsg, .partnerDeemph, .deemphApplied,
  .hotResetTsRx, .disabledTsRx, .enterHotReset, .enterDisabled, .activity_led_n);

// File: testbench/pplc_partner_model.sv
// Link partner model: asks for L1 while told to, stops on an answer, idles after an ack.
// Assumes the bench raises want to start a request and drops it to end one.
`timescale 1ns/1ps
module pplc_partner_model (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic want,
  input  wire logic pmRequestAckTx,
  input  wire logic pmNakTx,
  output logic      l1ReqRx,
  output logic      elecIdleRx
);
  logic got_q;
  // Request stays up until answered; a new one needs want to drop first
  always @(posedge ref_clk) begin
    if (reset || !want) begin
      l1ReqRx <= 1'h0;
      got_q <= 1'h0;
    end else begin
      got_q <= got_q | pmNakTx | pmRequestAckTx;
      l1ReqRx <= !(got_q | pmNakTx | pmRequestAckTx);
    end
    elecIdleRx <= !reset && pmRequestAckTx && got_q;
  end
endmodule // pplc_partner_model

// File: testbench/tb_top.sv
// Bench for the port link control block: APB tasks plus port stimulus, partner model on the L1 side.
// Assumes a short expander period of 20 cycles and the register offsets of the constants header.
`timescale 1ns/1ps
`include "pplc_consts.vh"
module tb_top;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic psel, penable, pwrite, isUpstreamPort, trainedDownLanes, isCrosslink, gen2Rate, l1AcceptOk;
  logic rxLanesActive, tlpTx, tlpRx, tlpIsVendorMsg, partnerDeemph, hotResetTsRx, disabledTsRx;
  logic hotResetDirect, want, pready, pslverr, pmRequestAckTx, pmNakTx, deemphAdvertise, deemphApplied;
  logic crosslinkEnable, speedChangeReq, enterRecovery, enterHotReset, enterDisabled, er;
  logic l1ReqRx, elecIdleRx, link_up_led_n, activity_led_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0]  linkState;
  int numErrors = 0;
  int comparisons = 0;
  int ev[5] = '{default: 0};
  int b[5];

  always #25 ref_clk = ~ref_clk;

  pplc_port_link_ctrl #(.EXP_PERIOD_CYC(20)) dut (
    .ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .isUpstreamPort, .trainedDownLanes, .isCrosslink, .gen2Rate, .linkState, .l1ReqRx, .l1AcceptOk,
    .elecIdleRx, .rxLanesActive, .pmRequestAckTx, .pmNakTx, .tlpTx, .tlpRx, .tlpIsVendorMsg,
    .partnerDeemph, .deemphAdvertise, .deemphApplied, .hotResetTsRx, .disabledTsRx, .hotResetDirect,
    .crosslinkEnable, .speedChangeReq, .enterRecovery, .enterHotReset, .enterDisabled,
    .link_up_led_n, .activity_led_n);

  pplc_partner_model u_partner (.ref_clk, .reset, .want, .pmRequestAckTx, .pmNakTx, .l1ReqRx, .elecIdleRx);

  // Event tallies: pulses are counted here so tests only compare differences
  always @(posedge ref_clk) begin
    ev[0] <= ev[0] + pmNakTx;
    ev[1] <= ev[1] + pmRequestAckTx;
    ev[2] <= ev[2] + enterHotReset;
    ev[3] <= ev[3] + enterRecovery;
    ev[4] <= ev[4] + enterDisabled;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n == 20) numErrors++;
    rdv = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic done(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", numErrors, comparisons);
    if (numErrors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    numErrors++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, isUpstreamPort, trainedDownLanes, isCrosslink, gen2Rate,
     linkState, l1AcceptOk, rxLanesActive, tlpTx, tlpRx, tlpIsVendorMsg, partnerDeemph, hotResetTsRx,
     disabledTsRx, hotResetDirect, want} = '0;
    cyc(12);
    reset <= 1'h0;
    apb(1'h0, `PPLC_OFF_REJ_TIMER, 32'h0);
    check(rdv, 32'h5F);
    check(crosslinkEnable, 32'h1);
    apb(1'h1, `PPLC_OFF_PRBS_SEED, 32'h0000A5A5);
    apb(1'h0, `PPLC_OFF_PRBS_SEED, 32'h0);
    check(rdv, 32'h0000A5A5);
    apb(1'h0, 12'h020, 32'h0);
    check({er, rdv[30:0]}, 32'h80000000);
    done("regs");
    isCrosslink <= 1'h1;
    isUpstreamPort <= 1'h1;
    linkState <= `PPLC_LS_L0;
    apb(1'h1, `PPLC_OFF_PHY_CFG0, 32'h1);
    cyc(2);
    check(crosslinkEnable, 32'h0);
    check(speedChangeReq, 32'h0);
    apb(1'h1, `PPLC_OFF_PHY_CFG0, 32'h2);
    cyc(2);
    check({crosslinkEnable, speedChangeReq}, 32'h3);
    done("crosslink");
    // Downstream keeps its own choice, upstream adopts the partner's decision
    isUpstreamPort <= 1'h0;
    gen2Rate <= 1'h1;
    linkState <= `PPLC_LS_RECOVERY;
    partnerDeemph <= 1'h1;
    apb(1'h1, `PPLC_OFF_LINK_CTRL2, 32'h0);
    cyc(4);
    check(deemphApplied, 32'h0);
    apb(1'h1, `PPLC_OFF_LINK_CTRL2, 32'h40);
    cyc(4);
    check(deemphApplied, 32'h1);
    isUpstreamPort <= 1'h1;
    partnerDeemph <= 1'h0;
    cyc(4);
    check({deemphAdvertise, deemphApplied}, 32'h2);
    gen2Rate <= 1'h0;
    cyc(4);
    check(deemphApplied, 32'h0);
    isUpstreamPort <= 1'h0;
    isCrosslink <= 1'h0;
    linkState <= `PPLC_LS_L0;
    done("deemph");
    apb(1'h1, `PPLC_OFF_LINK_CTRL, 32'h2);
    l1AcceptOk <= 1'h1;
    b = ev;
    want <= 1'h1;
    cyc(10);
    check(ev[1] - b[1] >= 2, 32'h1);
    check(pmRequestAckTx, 32'h0);
    want <= 1'h0;
    l1AcceptOk <= 1'h0;
    rxLanesActive <= 1'h1;
    apb(1'h1, `PPLC_OFF_REJ_TIMER, 32'hA);
    b = ev;
    want <= 1'h1;
    cyc(6);
    check(ev[0] - b[0], 32'h1);
    want <= 1'h0;
    cyc(1);
    want <= 1'h1;
    cyc(10);
    check(ev[0] - b[0], 32'h1);
    want <= 1'h0;
    cyc(30);
    want <= 1'h1;
    cyc(6);
    check(ev[0] - b[0], 32'h2);
    want <= 1'h0;
    cyc(30);
    apb(1'h1, `PPLC_OFF_REJ_TIMER, 32'h1000A);
    b = ev;
    want <= 1'h1;
    cyc(6);
    want <= 1'h0;
    cyc(40);
    want <= 1'h1;
    cyc(6);
    check(ev[0] - b[0], 32'h1);
    want <= 1'h0;
    rxLanesActive <= 1'h0;
    cyc(30);
    want <= 1'h1;
    cyc(6);
    check(ev[0] - b[0], 32'h2);
    want <= 1'h0;
    done("l1");
    // Vendor messages must not light the activity output
    tlpRx <= 1'h1;
    tlpIsVendorMsg <= 1'h1;
    cyc(1);
    tlpRx <= 1'h0;
    tlpIsVendorMsg <= 1'h0;
    cyc(60);
    check(activity_led_n, 32'h1);
    tlpTx <= 1'h1;
    cyc(1);
    tlpTx <= 1'h0;
    cyc(25);
    check(activity_led_n, 32'h0);
    cyc(60);
    check(activity_led_n, 32'h0);
    cyc(80);
    check(activity_led_n, 32'h1);
    for (int s = 0; s < 7; s++) begin
      linkState <= s[2:0];
      cyc(45);
      check(link_up_led_n, !(s >= 1 && s <= 4));
    end
    done("status");
    linkState <= `PPLC_LS_L0;
    for (int t = 0; t < 2; t++) begin
      trainedDownLanes <= t[0];
      b = ev;
      hotResetDirect <= 1'h1;
      cyc(1);
      hotResetDirect <= 1'h0;
      cyc(2);
      linkState <= `PPLC_LS_RECOVERY;
      cyc(8);
      check({ev[3] > b[3], ev[2] > b[2]}, {t[0], t[0]});
      apb(1'h0, `PPLC_OFF_PORT_STATUS, 32'h0);
      check(rdv[`PPLC_ST_ROLE_BIT], t[0]);
      linkState <= `PPLC_LS_L0;
    end
    trainedDownLanes <= 1'h0;
    b = ev;
    hotResetTsRx <= 1'h1;
    cyc(1);
    hotResetTsRx <= 1'h0;
    cyc(6);
    check(ev[2] > b[2], 32'h1);
    apb(1'h0, `PPLC_OFF_LINK_CTRL, 32'h0);
    check(rdv, 32'h2);
    b = ev;
    apb(1'h1, `PPLC_OFF_LINK_CTRL, 32'h12);
    cyc(2);
    linkState <= `PPLC_LS_RECOVERY;
    cyc(6);
    check({ev[3] > b[3], ev[4] > b[4]}, 32'h3);
    apb(1'h1, `PPLC_OFF_LINK_CTRL, 32'h2);
    linkState <= `PPLC_LS_L0;
    isUpstreamPort <= 1'h1;
    b = ev;
    disabledTsRx <= 1'h1;
    cyc(1);
    disabledTsRx <= 1'h0;
    cyc(6);
    check(ev[4] > b[4], 32'h1);
    done("reset_disable");
    conclude();
  end
endmodule // tb_top
